// file: alsu_core.v
// arithmetic, logic and shift execution unit of the cpu datapath
`timescale 1ns/1ps
`include "alsu_consts.vh"
module alsu_core
(
  input wire mclk_i,
  input wire resetn_i,
  input wire start_i, // one-cycle request from decoder
  input wire [`ALSU_OP_W-1:0] op_i,
  input wire word_i, // word size when high
  input wire use_imm_i, // second operand from immediate
  input wire [15:0] dst_i, // destination register value
  input wire [15:0] src_i, // source register value
  input wire [15:0] imm_i, // immediate, low byte for byte ops
  input wire [`ALSU_FLG_W-1:0] flags_i, // n z v c
  input wire half_i, // half carry of previous add/sub
  output reg [15:0] result_o,
  output reg [`ALSU_FLG_W-1:0] flags_o,
  output reg half_o,
  output reg write_o, // write result to destination
  output reg done_o, // result valid pulse
  output reg illegal_o, // unsupported operand form
  output reg busy_o
);
  localparam ST_IDLE = 2'h0; // waiting for request
  localparam ST_DIV = 2'h1; // division in progress
  localparam [3:0] DIV_LAST = `ALSU_DIV_LAST; // eight steps
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [3:0] cnt_r; // division step counter
  reg [15:0] rem_r; // partial remainder
  reg [7:0] quo_r; // quotient bits
  reg [7:0] dvs_r; // divisor
  reg [7:0] dvd_r; // remaining dividend low bits
  reg [15:0] b_op; // second operand
  reg [16:0] sum; // extended adder output
  reg [15:0] res;
  reg [`ALSU_FLG_W-1:0] flg;
  reg hc; // half carry
  reg wr;
  reg bad;
  reg wide; // result is 16 bits
  reg arith; // overflow/carry from adder
  reg subop;
  reg [15:0] a_op;
  reg [15:0] b_add;
  reg cin;
  wire cflag = flags_i[`ALSU_FLG_C];
  wire [7:0] sh_res;
  wire sh_c;
  wire sh_v;
  wire [7:0] da_res;
  wire da_c;
  wire [16:0] trial = {rem_r[15:0], dvd_r[7]} - {9'h000, dvs_r};
  alsu_shifter u_shift
  (
    .op_i(op_i),
    .val_i(dst_i[7:0]),
    .carry_i(cflag),
    .res_o(sh_res),
    .carry_o(sh_c),
    .ovf_o(sh_v)
  );
  alsu_decadj u_dadj
  (
    .sub_i(op_i == `ALSU_OP_ADJS),
    .val_i(dst_i[7:0]),
    .carry_i(cflag),
    .half_i(half_i),
    .res_o(da_res),
    .carry_o(da_c)
  );
  // single-cycle operations: operand select, adder, flags
  always @*
  begin
    b_op = use_imm_i ? imm_i : src_i;
    if (!word_i)
      b_op = {8'h00, b_op[7:0]};
    a_op = word_i ? dst_i : {8'h00, dst_i[7:0]};
    b_add = b_op;
    cin = 1'b0;
    subop = 1'b0;
    arith = 1'b1;
    wide = word_i;
    wr = 1'b1;
    bad = 1'b0;
    case (op_i)
      `ALSU_OP_ADD:
        bad = word_i & use_imm_i;
      `ALSU_OP_SUB:
      begin
        subop = 1'b1;
        bad = use_imm_i;
      end
      `ALSU_OP_ADDC:
      begin
        cin = cflag;
        wide = 1'b0;
        bad = word_i;
      end
      `ALSU_OP_SUBC:
      begin
        subop = 1'b1;
        cin = cflag;
        wide = 1'b0;
        bad = word_i;
      end
      `ALSU_OP_INC:
      begin
        b_add = 16'h0001;
        wide = 1'b0;
      end
      `ALSU_OP_DECR:
      begin
        subop = 1'b1;
        b_add = 16'h0001;
        wide = 1'b0;
      end
      `ALSU_OP_ADDQ,
      `ALSU_OP_SUBQ:
      begin
        a_op = dst_i;
        arith = 1'b0; // address-style step: flags left alone
        subop = (op_i == `ALSU_OP_SUBQ);
        b_add = {14'h0000, imm_i[1:0]};
        wide = 1'b1;
        bad = (imm_i != 16'h0001) && (imm_i != 16'h0002);
      end
      `ALSU_OP_COMPARE:
      begin
        subop = 1'b1;
        wr = 1'b0;
        bad = word_i & use_imm_i;
      end
      `ALSU_OP_NEG:
      begin
        a_op = 16'h0000;
        b_add = {8'h00, dst_i[7:0]};
        subop = 1'b1;
        wide = 1'b0;
      end
      default:
      begin
        arith = 1'b0;
        wide = 1'b0;
      end
    endcase
    // subtract as a plus inverted b plus inverted borrow
    if (subop && !wide) // invert low byte only: bit 8 is the inverted borrow
      sum = {1'b0, a_op} + {9'h000, ~b_add[7:0]} + {16'h0000, ~cin};
    else if (subop)
      sum = {1'b0, a_op} + {1'b0, ~b_add} + {16'h0000, ~cin};
    else
      sum = {1'b0, a_op} + {1'b0, b_add} + {16'h0000, cin};
    if (!wide)
      sum = {8'h00, sum[8:0]};
    res = sum[15:0];
    hc = subop ? (a_op[3:0] < b_add[3:0]) : (sum[4] ^ a_op[4] ^ b_add[4]);
    flg = flags_i;
    if (arith)
    begin
      if (wide)
      begin
        flg[`ALSU_FLG_C] = subop ? ~sum[16] : sum[16];
        flg[`ALSU_FLG_V] = subop ?
          ((a_op[15] ^ b_add[15]) & (a_op[15] ^ sum[15])) :
          (~(a_op[15] ^ b_add[15]) & (a_op[15] ^ sum[15]));
      end
      else
      begin
        flg[`ALSU_FLG_C] = subop ? ~sum[8] : sum[8];
        flg[`ALSU_FLG_V] = subop ?
          ((a_op[7] ^ b_add[7]) & (a_op[7] ^ sum[7])) :
          (~(a_op[7] ^ b_add[7]) & (a_op[7] ^ sum[7]));
      end
    end
    // non-adder operations
    case (op_i)
      `ALSU_OP_AND: res = {8'h00, dst_i[7:0] & b_op[7:0]};
      `ALSU_OP_OR: res = {8'h00, dst_i[7:0] | b_op[7:0]};
      `ALSU_OP_XOR: res = {8'h00, dst_i[7:0] ^ b_op[7:0]};
      `ALSU_OP_NOT: res = {8'h00, ~dst_i[7:0]};
      `ALSU_OP_ADJA,
      `ALSU_OP_ADJS:
      begin
        res = {8'h00, da_res};
        flg[`ALSU_FLG_C] = da_c;
      end
      `ALSU_OP_MUL:
      begin
        res = {8'h00, dst_i[7:0]} * {8'h00, src_i[7:0]};
        wide = 1'b1;
      end
      `ALSU_OP_ASHL, `ALSU_OP_ASHR, `ALSU_OP_LSHL, `ALSU_OP_LSHR,
      `ALSU_OP_ROL, `ALSU_OP_ROR, `ALSU_OP_RCL, `ALSU_OP_RCR:
      begin
        res = {8'h00, sh_res};
        flg[`ALSU_FLG_C] = sh_c;
        flg[`ALSU_FLG_V] = sh_v;
      end
      default: res = res; // adder result kept
    endcase
    // logic ops clear overflow; word small add leaves flags alone
    if (op_i == `ALSU_OP_AND || op_i == `ALSU_OP_OR ||
        op_i == `ALSU_OP_XOR || op_i == `ALSU_OP_NOT)
      flg[`ALSU_FLG_V] = 1'b0;
    if (op_i != `ALSU_OP_ADDQ && op_i != `ALSU_OP_SUBQ &&
        op_i != `ALSU_OP_MUL)
    begin
      flg[`ALSU_FLG_N] = wide ? res[15] : res[7];
      flg[`ALSU_FLG_Z] = wide ? (res == 16'h0000) : (res[7:0] == 8'h00);
    end
    // byte ops keep the destination upper byte
    if (!wide)
      res = {dst_i[15:8], res[7:0]};
  end
  // division sequencer state
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (start_i && op_i == `ALSU_OP_DIV && src_i[7:0] != 8'h00)
          state_nxt = ST_DIV;
      ST_DIV:
        if (cnt_r == DIV_LAST)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end
  // registered outputs and restoring divider, one bit per clock
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      rem_r <= 16'h0000;
      quo_r <= 8'h00;
      dvs_r <= 8'h00;
      dvd_r <= 8'h00;
      result_o <= 16'h0000;
      flags_o <= 4'h0;
      half_o <= 1'b0;
      write_o <= 1'b0;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      done_o <= 1'b0;
      write_o <= 1'b0;
      illegal_o <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (start_i && op_i == `ALSU_OP_DIV)
          begin
            if (src_i[7:0] == 8'h00)
            begin
              // divide by zero: refused, destination kept
              illegal_o <= 1'b1;
              done_o <= 1'b1;
            end
            else
            begin
              rem_r <= {8'h00, dst_i[15:8]};
              dvd_r <= dst_i[7:0];
              dvs_r <= src_i[7:0];
              cnt_r <= 4'h0;
              busy_o <= 1'b1;
            end
          end
          else if (start_i)
          begin
            done_o <= 1'b1;
            illegal_o <= bad;
            write_o <= wr & ~bad;
            if (!bad)
            begin
              result_o <= res;
              flags_o <= flg;
              half_o <= hc;
            end
          end
        end
        ST_DIV:
        begin
          if (!trial[16])
            rem_r <= trial[15:0];
          else
            rem_r <= {rem_r[14:0], dvd_r[7]};
          quo_r <= {quo_r[6:0], ~trial[16]};
          dvd_r <= {dvd_r[6:0], 1'b0};
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == DIV_LAST)
          begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
            write_o <= 1'b1;
            // remainder high, quotient low
            result_o <= {(trial[16] ? {rem_r[6:0], dvd_r[7]} : trial[7:0]),
              quo_r[6:0], ~trial[16]};
            flags_o[`ALSU_FLG_Z] <= ({quo_r[6:0], ~trial[16]} == 8'h00);
            flags_o[`ALSU_FLG_N] <= quo_r[6];
          end
        end
        default: busy_o <= 1'b0;
      endcase
    end
  end
endmodule // alsu_core

// file: alsu_consts.vh
// operation codes, flag positions and widths for the arithmetic, logic and shift unit
`ifndef ALSU_CONSTS_VH
`define ALSU_CONSTS_VH
`define ALSU_OP_W 5
`define ALSU_OP_ADD 5'h00
`define ALSU_OP_SUB 5'h01
`define ALSU_OP_ADDC 5'h02
`define ALSU_OP_SUBC 5'h03
`define ALSU_OP_INC 5'h04
`define ALSU_OP_DECR 5'h05
`define ALSU_OP_ADDQ 5'h06
`define ALSU_OP_SUBQ 5'h07
`define ALSU_OP_ADJA 5'h08
`define ALSU_OP_ADJS 5'h09
`define ALSU_OP_MUL 5'h0a
`define ALSU_OP_DIV 5'h0b
`define ALSU_OP_COMPARE 5'h0c
`define ALSU_OP_NEG 5'h0d
`define ALSU_OP_AND 5'h0e
`define ALSU_OP_OR 5'h0f
`define ALSU_OP_XOR 5'h10
`define ALSU_OP_NOT 5'h11
`define ALSU_OP_ASHL 5'h12
`define ALSU_OP_ASHR 5'h13
`define ALSU_OP_LSHL 5'h14
`define ALSU_OP_LSHR 5'h15
`define ALSU_OP_ROL 5'h16
`define ALSU_OP_ROR 5'h17
`define ALSU_OP_RCL 5'h18
`define ALSU_OP_RCR 5'h19
`define ALSU_FLG_C 0
`define ALSU_FLG_V 1
`define ALSU_FLG_Z 2
`define ALSU_FLG_N 3
`define ALSU_FLG_W 4
`define ALSU_DIV_LAST 4'h7
`endif

// file: alsu_shifter.v
// single-bit shift and rotate unit for byte operands
`timescale 1ns/1ps
`include "alsu_consts.vh"
module alsu_shifter
(
  input wire [`ALSU_OP_W-1:0] op_i,
  input wire [7:0] val_i,
  input wire carry_i,
  output reg [7:0] res_o,
  output reg carry_o,
  output reg ovf_o
);
  // one position per operation; out-going bit lands in carry
  always @*
  begin
    res_o = val_i;
    carry_o = carry_i;
    ovf_o = 1'b0;
    case (op_i)
      `ALSU_OP_ASHL:
      begin
        res_o = {val_i[6:0], 1'b0};
        carry_o = val_i[7];
        ovf_o = val_i[7] ^ val_i[6]; // sign change
      end
      `ALSU_OP_ASHR:
      begin
        res_o = {val_i[7], val_i[7:1]};
        carry_o = val_i[0];
      end
      `ALSU_OP_LSHL:
      begin
        res_o = {val_i[6:0], 1'b0};
        carry_o = val_i[7];
      end
      `ALSU_OP_LSHR:
      begin
        res_o = {1'b0, val_i[7:1]};
        carry_o = val_i[0];
      end
      `ALSU_OP_ROL:
      begin
        res_o = {val_i[6:0], val_i[7]};
        carry_o = val_i[7];
      end
      `ALSU_OP_ROR:
      begin
        res_o = {val_i[0], val_i[7:1]};
        carry_o = val_i[0];
      end
      `ALSU_OP_RCL:
      begin
        res_o = {val_i[6:0], carry_i};
        carry_o = val_i[7];
      end
      `ALSU_OP_RCR:
      begin
        res_o = {carry_i, val_i[7:1]};
        carry_o = val_i[0];
      end
      default:
      begin
        res_o = val_i; // not a shift: pass through
      end
    endcase
  end
endmodule // alsu_shifter

// file: alsu_decadj.v
// packed bcd correction after byte add or subtract
`timescale 1ns/1ps
module alsu_decadj
(
  input wire sub_i,
  input wire [7:0] val_i,
  input wire carry_i,
  input wire half_i,
  output reg [7:0] res_o,
  output reg carry_o
);
  reg [7:0] corr; // correction added or subtracted
  reg lo_fix; // low digit needs six
  reg hi_fix; // high digit needs sixty
  // correction chosen from carry, half carry and the digits
  always @*
  begin
    corr = 8'h00;
    lo_fix = half_i | (!sub_i && (val_i[3:0] > 4'h9));
    hi_fix = carry_i | (!sub_i && (val_i > 8'h99));
    if (lo_fix)
      corr = corr | 8'h06;
    if (hi_fix)
      corr = corr | 8'h60;
    if (sub_i)
      res_o = val_i - corr;
    else
      res_o = val_i + corr;
    carry_o = hi_fix;
  end
endmodule // alsu_decadj

// file: alsu_core_checker.sv
// port-level assertions for the arithmetic, logic and shift unit
`timescale 1ns/1ps
`include "alsu_consts.vh"
module alsu_core_checker
(
  input wire mclk_i,
  input wire resetn_i,
  input wire start_i,
  input wire [`ALSU_OP_W-1:0] op_i,
  input wire word_i,
  input wire use_imm_i,
  input wire [15:0] dst_i,
  input wire [15:0] src_i,
  input wire [15:0] result_o,
  input wire write_o,
  input wire done_o,
  input wire illegal_o,
  input wire busy_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // a request counts only when the divider is idle
  wire take = start_i && !busy_o;
  // divide: eight busy cycles, then the answer with busy dropped
  sequence s_div_run;
    busy_o [*8] ##1 (done_o && !busy_o);
  endsequence
  chk_single_cycle_done: assert property (take && op_i != 5'h0b |=> done_o)
    else $error("single-cycle op gave no done");
  chk_div_busy_run: assert property (take && op_i == 5'h0b
    && src_i[7:0] != 8'h00 |=> s_div_run)
    else $error("divide timing wrong");
  chk_write_only_done: assert property (write_o |-> done_o && !illegal_o)
    else $error("write outside a legal done");
  chk_sub_imm_refused: assert property (take && op_i == 5'h01 && use_imm_i
    |=> illegal_o && !write_o)
    else $error("immediate subtract accepted");
  chk_word_imm_refused: assert property (take && word_i && use_imm_i
    && (op_i == 5'h00 || op_i == 5'h0c) |=> illegal_o)
    else $error("word immediate form accepted");
  chk_cmp_no_write: assert property (take && op_i == 5'h0c |=> !write_o)
    else $error("compare wrote destination");
  chk_inc_by_one: assert property (take && op_i == 5'h04
    |=> result_o[7:0] == $past(dst_i[7:0]) + 8'h01)
    else $error("increment not by one");
  chk_neg_value: assert property (take && op_i == 5'h0d
    |=> result_o[7:0] == 8'h00 - $past(dst_i[7:0]))
    else $error("negate value wrong");
  chk_not_value: assert property (take && op_i == 5'h11
    |=> result_o[7:0] == ~$past(dst_i[7:0]))
    else $error("complement value wrong");
  chk_mul_product: assert property (take && op_i == 5'h0a
    |=> result_o == $past(dst_i[7:0]) * $past(src_i[7:0]))
    else $error("product wrong");
endmodule // alsu_core_checker

// file: alsu_regfile_model.sv
// destination register and flag register on the decoder side
`timescale 1ns/1ps
module alsu_regfile_model
(
  input wire mclk_i,
  input wire [15:0] result_i,
  input wire [3:0] flags_i,
  input wire write_i,
  input wire done_i,
  input wire illegal_i,
  output reg [15:0] dst_o,
  output reg [3:0] flagreg_o
);
  // write-back only on the write pulse, so compare leaves dst alone
  always @(posedge mclk_i)
  begin
    if (write_i)
      dst_o <= result_i;
    if (done_i && !illegal_i)
      flagreg_o <= flags_i;
  end
  // bench preloads operands between operations, never mid-request
  task preload(input [15:0] d, input [3:0] f);
  begin
    dst_o = d;
    flagreg_o = f;
  end
  endtask
endmodule // alsu_regfile_model

// file: alsu_core_test.sv
// self-checking bench for the arithmetic, logic and shift unit
`timescale 1ns/1ps
module alsu_core_test;
  reg mclk_i = 1'b0;
  reg resetn_i = 1'b0;
  reg start_i = 1'b0;
  reg word_i = 1'b0;
  reg use_imm_i = 1'b0;
  reg half_i = 1'b0;
  reg [4:0] op_i = 5'h00;
  reg [15:0] src_i = 16'h0000;
  reg [15:0] imm_i = 16'h0000;
  reg seen_ill;
  wire [15:0] dst, result_o;
  wire [3:0] flagreg, flags_o;
  wire write_o, done_o, illegal_o, busy_o, half_o;
  integer n_errors = 0;
  integer checks_done = 0;
  integer i;
  // expected shift results of 8'h41 with carry in set, one byte per op
  localparam [63:0] SHX = 64'h8220822082a083a0;
  // 40 MHz clock
  always #12.5 mclk_i = ~mclk_i;
  alsu_core u_alsu_core (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .start_i(start_i), .op_i(op_i), .word_i(word_i), .use_imm_i(use_imm_i),
    .dst_i(dst), .src_i(src_i), .imm_i(imm_i), .flags_i(flagreg),
    .half_i(half_i), .result_o(result_o), .flags_o(flags_o), .half_o(half_o),
    .write_o(write_o), .done_o(done_o), .illegal_o(illegal_o),
    .busy_o(busy_o));
  alsu_regfile_model u_alsu_regfile_model (.mclk_i(mclk_i),
    .result_i(result_o), .flags_i(flags_o), .write_i(write_o),
    .done_i(done_o), .illegal_i(illegal_o), .dst_o(dst),
    .flagreg_o(flagreg));
  // counts every compare, reports a mismatch at once
  task check(input [15:0] got, input [15:0] exp);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask
  task give_verdict;
  begin
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  // one request pulse, bounded wait for done, then compare write-back
  task run(input [4:0] o, input w, u, input [15:0] d, s, m,
    input [3:0] f, input h, ei, input [15:0] ed, input [3:0] ec, fm);
  integer k;
  begin
    u_alsu_regfile_model.preload(d, f);
    op_i = o;
    word_i = w;
    use_imm_i = u;
    src_i = s;
    imm_i = m;
    half_i = h;
    start_i = 1'b1;
    @(negedge mclk_i);
    start_i = 1'b0;
    k = 0;
    while (done_o !== 1'b1 && k < 20)
    begin
      @(negedge mclk_i);
      k = k + 1;
    end
    if (k == 20)
    begin
      n_errors = n_errors + 1;
      give_verdict;
    end
    seen_ill = illegal_o;
    // one more edge so the model has taken the write-back
    @(negedge mclk_i);
    check({15'h0000, seen_ill}, {15'h0000, ei});
    check(dst, ed);
    check({12'h000, flagreg & fm}, {12'h000, ec & fm});
    $display("test op %h finished", o);
  end
  endtask
  initial
  begin
    u_alsu_regfile_model.preload(16'h0000, 4'h0);
    repeat (2) @(negedge mclk_i);
    check(result_o, 16'h0000);
    resetn_i = 1'b1;
    run(5'h00,0,0,16'h127f,16'h0001,0,4'h0,0,0,16'h1280,4'ha,4'hf);
    check({15'h0000, half_o}, 16'h0001);
    run(5'h00,0,1,16'h0001,0,16'h00ff,4'h0,0,0,16'h0000,4'h5,4'hf);
    run(5'h01,0,1,16'h0005,0,16'h0001,4'h0,0,1,16'h0005,4'h0,4'hf);
    run(5'h01,0,0,16'h0010,16'h0020,0,4'h0,0,0,16'h00f0,4'h9,4'hf);
    run(5'h00,1,0,16'h8000,16'h8000,0,4'h0,0,0,16'h0000,4'h7,4'hf);
    run(5'h00,1,1,16'h1234,0,16'h0001,4'h0,0,1,16'h1234,4'h0,4'hf);
    run(5'h02,0,0,16'h0010,16'h0020,0,4'h1,0,0,16'h0031,4'h0,4'hf);
    run(5'h03,0,1,16'h0010,0,16'h0005,4'h1,0,0,16'h000a,4'h0,4'hf);
    run(5'h02,1,0,16'h0010,16'h0020,0,4'h0,0,1,16'h0010,4'h0,4'hf);
    run(5'h04,0,0,16'h00ff,0,0,4'h0,0,0,16'h0000,4'h4,4'h4);
    run(5'h05,0,0,16'h0080,0,0,4'h0,0,0,16'h007f,4'h0,4'h8);
    run(5'h06,1,1,16'hfffe,0,16'h0002,4'ha,0,0,16'h0000,4'ha,4'hf);
    run(5'h07,1,1,16'h0000,0,16'h0003,4'h0,0,1,16'h0000,4'h0,4'hf);
    run(5'h08,0,0,16'h000a,0,0,4'h0,0,0,16'h0010,4'h0,4'h1);
    run(5'h09,0,0,16'h000f,0,0,4'h0,1,0,16'h0009,4'h0,4'h0);
    run(5'h0a,0,0,16'h00ff,16'h00ff,0,4'h5,0,0,16'hfe01,4'h5,4'hf);
    run(5'h0b,0,0,16'h1234,16'h0056,0,4'h0,0,0,16'h1036,4'h0,4'h0);
    run(5'h0b,0,0,16'h1234,16'h0000,0,4'h0,0,1,16'h1234,4'h0,4'h0);
    run(5'h0c,0,0,16'h0005,16'h0005,0,4'h0,0,0,16'h0005,4'h4,4'hf);
    run(5'h0c,1,1,16'h0005,0,16'h0005,4'h0,0,1,16'h0005,4'h0,4'hf);
    run(5'h0d,0,0,16'h0001,0,0,4'h0,0,0,16'h00ff,4'h8,4'h8);
    run(5'h0e,0,1,16'h00c3,0,16'h005a,4'h0,0,0,16'h0042,4'h0,4'he);
    run(5'h0f,0,0,16'h00c3,16'h005a,0,4'h0,0,0,16'h00db,4'h8,4'he);
    run(5'h10,0,1,16'h00c3,0,16'h005a,4'h0,0,0,16'h0099,4'h8,4'he);
    run(5'h11,0,0,16'h000f,0,0,4'h0,0,0,16'h00f0,4'h0,4'h0);
    for (i = 0; i < 8; i = i + 1)
      run(5'h12 + i[4:0], 0, 0, 16'h0041, 0, 0, 4'h1, 0, 0,
        {8'h00, SHX[63-8*i -: 8]}, {3'h0, i[0]}, 4'h1);
    give_verdict;
  end
endmodule // alsu_core_test
bind alsu_core alsu_core_checker u_alsu_core_checker (.mclk_i(mclk_i),
  .resetn_i(resetn_i), .start_i(start_i), .op_i(op_i), .word_i(word_i),
  .use_imm_i(use_imm_i), .dst_i(dst_i), .src_i(src_i),
  .result_o(result_o), .write_o(write_o), .done_o(done_o),
  .illegal_o(illegal_o), .busy_o(busy_o));
